// File: detector_map.vh
`ifndef DETECTOR_MAP_VH
`define DETECTOR_MAP_VH
// Clock rate and timing figures
`define CLK_HZ 10000000
`define ENTRY_DELAY_MS 2000
`define PULSE_MS 250
`define EXT_SHORT_MS 2000
`define EXT_MID_MS 5000
`define EXT_LONG_MS 10000
`define LIMITED_MIN_S 300
`define HOLD_MEMORY_MS 4000
`define REF_ADOPT_MS 2000
`define LONG_PRESS_MS 2000
`define FLASH_SLOT_MS 250
`define FREQ_SHOW_MS 3000
// Option switch positions
`define SW_BOOST 0
`define SW_LIMITED 1
`define SW_DELAY 2
`define SW_EXT_LO 3
`define SW_EXT_HI 4
`define SW_BMODE_LO 5
`define SW_BMODE_HI 6
// Output B modes, {sw7, sw6}
`define BMODE_ENTRY 2'b00
`define BMODE_EXIT 2'b10
`define BMODE_DUP 2'b01
`define BMODE_FAULT 2'b11
// Fault codes
`define FAULT_NONE 2'd0
`define OPEN_LOOP_CODE 2'd1
`define SHORTED_LOOP_CODE 2'd2
`define INDUCTANCE_JUMP_CODE 2'd3
// Display glyphs
`define GLYPH_ZERO 7'h3f
`define GLYPH_D 7'h5e
`define GLYPH_E 7'h79
`define GLYPH_F 7'h71
`define GLYPH_DASH 7'h40
`endif

// File: flash_pattern.v
`timescale 1ns/1ps
`default_nettype none
`include "detector_map.vh"
// Emits n flashes then a gap, repeated; n = fault code.
module flash_pattern #(
   parameter SLOT_CYC = 2500000
) (
   input wire clk,
   input wire reset_n,
   input wire ce,
   input wire [1:0] code,
   output reg lit_q
);
   reg [31:0] slot_q;
   reg [3:0] step_q;
   wire slot_end = (slot_q == SLOT_CYC - 1);
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         slot_q <= 32'h0;
         step_q <= 4'h0;
         lit_q <= 1'b0;
      end else if (ce) begin
         slot_q <= slot_end ? 32'h0 : slot_q + 32'h1;
         if (slot_end) begin
            step_q <= (step_q == 4'h9) ? 4'h0 : step_q + 4'h1;
         end
         // Even slots light while under code*2; rest of the 10 slots is the gap
         lit_q <= (code != `FAULT_NONE) && !step_q[0] && (step_q < {1'b0, code, 1'b0});
      end
   end
endmodule
`default_nettype wire

// File: loop_detector_output_control.v
// Behaviour
// - Switch 1 boosts sensitivity only while the call is active
// - Switch 2 on limits output A hold to a bounded time
// - Switch 2 off holds output A while vehicle stays
// - Switch 3 on withholds calls until 2 s continuous presence
// - Leaving during the entry delay cancels it, no calls at all
// - Switches 4 and 5 pick 0, 2, 5 or 10 s extension
// - Extension applies only to the presence call: output A, and B in duplicate mode
// - Switches 6 and 7 pick output B mode
// - Output A is always a presence output
// - Entry mode: one 250 ms B pulse per entry from idle; a re-entry during extension gives none
// - Exit mode: one 250 ms B pulse per exit
// - Duplicate mode: B mirrors A
// - Fault mode: B on while a fault is current
// - Reset press or power loss of 4 s or more clears state, retunes, flashes frequency digits
// - A call survives a power loss shorter than 4 s
// - Faults are open, shorted, or inductance jump above 25%
// - Current fault flashes both indicators with its code and shows F on the display
// - Healed fault keeps flashing fault indicator only
// - After inductance jump, adopt new reference after 2 s
// - Reset press stops remembered fault flashing
// - Last fault kept in non-volatile store, shown at power-up
// - Holding reset 2 s shows the stored last fault
// - Single, double, triple flashes for the three fault kinds
`timescale 1ns/1ps
`default_nettype none
`include "detector_map.vh"
module loop_detector_output_control #(
   parameter CLK_HZ = `CLK_HZ,
   parameter LIMITED_HOLD_S = `LIMITED_MIN_S,
   parameter ENTRY_CYC = `ENTRY_DELAY_MS * (`CLK_HZ / 1000),
   parameter PULSE_CYC = `PULSE_MS * (`CLK_HZ / 1000),
   parameter EXT_SHORT_CYC = `EXT_SHORT_MS * (`CLK_HZ / 1000),
   parameter EXT_MID_CYC = `EXT_MID_MS * (`CLK_HZ / 1000),
   parameter EXT_LONG_CYC = `EXT_LONG_MS * (`CLK_HZ / 1000),
   parameter LIMITED_CYC = `LIMITED_MIN_S * `CLK_HZ,
   parameter MEMORY_CYC = `HOLD_MEMORY_MS * (`CLK_HZ / 1000),
   parameter ADOPT_CYC = `REF_ADOPT_MS * (`CLK_HZ / 1000),
   parameter LONG_PRESS_CYC = `LONG_PRESS_MS * (`CLK_HZ / 1000),
   parameter FREQ_SHOW_CYC = `FREQ_SHOW_MS * (`CLK_HZ / 1000),
   parameter SLOT_CYC = `FLASH_SLOT_MS * (`CLK_HZ / 1000)
) (
   input wire CLK,
   input wire RESET_N,
   input wire CE,
   input wire [7:0] OPTION_SW,
   input wire VEHICLE_PRESENT,
   input wire OPEN_LOOP,
   input wire SHORTED_LOOP,
   input wire INDUCTANCE_JUMP,
   input wire RESET_BUTTON,
   input wire POWER_GOOD,
   input wire [1:0] STORED_FAULT,
   output reg CALL_A,
   output reg CALL_B,
   output reg SENS_BOOST,
   output reg RETUNE,
   output reg ADOPT_REFERENCE,
   output reg SHOW_FREQUENCY,
   output reg OUTPUT_LED,
   output reg FAULT_LED,
   output reg [6:0] SEGMENTS,
   output reg [1:0] FAULT_STORE_DATA,
   output reg FAULT_STORE_WRITE
);
   // Call state machine, one-hot
   localparam S_IDLE = 4'b0001;
   localparam S_DELAY = 4'b0010;
   localparam S_CALL = 4'b0100;
   localparam S_EXT = 4'b1000;

   // Pins are asynchronous; two stages each
   reg [6:0] sync1_q;
   reg [6:0] sync2_q;
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sync1_q <= 7'h0;
         sync2_q <= 7'h0;
      end else if (CE) begin
         sync1_q <= {POWER_GOOD, RESET_BUTTON, INDUCTANCE_JUMP, SHORTED_LOOP, OPEN_LOOP,
                     VEHICLE_PRESENT, 1'b0};
         sync2_q <= sync1_q;
      end
   end
   wire veh = sync2_q[1];
   wire f_open = sync2_q[2];
   wire f_short = sync2_q[3];
   wire f_jump = sync2_q[4];
   wire btn = sync2_q[5];
   wire pwr = sync2_q[6];

   // Priority: open beats short beats jump
   function [1:0] fault_code;
      input o, s, j;
      begin
         fault_code = o ? `OPEN_LOOP_CODE : s ? `SHORTED_LOOP_CODE :
                      j ? `INDUCTANCE_JUMP_CODE : `FAULT_NONE;
      end
   endfunction

   function [31:0] ext_cycles;
      input [1:0] sel;
      begin
         case (sel)
            2'b01: ext_cycles = EXT_SHORT_CYC;
            2'b10: ext_cycles = EXT_MID_CYC;
            2'b11: ext_cycles = EXT_LONG_CYC;
            default: ext_cycles = 32'h0;
         endcase
      end
   endfunction

   wire [1:0] cur_fault = fault_code(f_open, f_short, f_jump);
   wire faulted = (cur_fault != `FAULT_NONE);
   wire [1:0] bmode = {OPTION_SW[`SW_BMODE_HI], OPTION_SW[`SW_BMODE_LO]};
   wire [1:0] ext_sel = {OPTION_SW[`SW_EXT_HI], OPTION_SW[`SW_EXT_LO]};

   reg [3:0] state_q;
   reg [31:0] tmr_q;
   reg [31:0] pres_q;
   reg [31:0] pulse_q;
   reg [31:0] outage_q;
   reg [31:0] press_q;
   reg [31:0] adopt_q;
   reg [31:0] show_q;
   reg veh_prev_q;
   reg btn_prev_q;
   reg pwr_prev_q;
   reg timed_out_q;
   reg [1:0] last_fault_q;
   reg [1:0] led_fault_q;
   reg jump_prev_q;
   reg boot_q;

   wire entry = veh && !veh_prev_q;
   wire leave = !veh && veh_prev_q;
   wire short_press = !btn && btn_prev_q && (press_q < LONG_PRESS_CYC);
   wire restored = pwr && !pwr_prev_q;
   // A brief outage keeps the call; a long one clears like reset
   wire clear_all = short_press || (restored && outage_q >= MEMORY_CYC);
   wire long_held = btn && (press_q >= LONG_PRESS_CYC);
   wire call_on = (state_q == S_CALL) || (state_q == S_EXT);

   wire [1:0] pat_code = faulted ? cur_fault : led_fault_q;
   wire pat_lit;
   flash_pattern #(
      .SLOT_CYC(SLOT_CYC)
   ) u_flash (
      .clk(CLK),
      .reset_n(RESET_N),
      .ce(CE),
      .code(pat_code),
      .lit_q(pat_lit)
   );

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q <= S_IDLE;
         tmr_q <= 32'h0;
         pres_q <= 32'h0;
         pulse_q <= 32'h0;
         outage_q <= 32'h0;
         press_q <= 32'h0;
         adopt_q <= 32'h0;
         show_q <= 32'h0;
         veh_prev_q <= 1'b0;
         btn_prev_q <= 1'b0;
         pwr_prev_q <= 1'b0;
         timed_out_q <= 1'b0;
         last_fault_q <= `FAULT_NONE;
         led_fault_q <= `FAULT_NONE;
         jump_prev_q <= 1'b0;
         boot_q <= 1'b1;
      end else if (CE) begin
         veh_prev_q <= veh;
         btn_prev_q <= btn;
         pwr_prev_q <= pwr;
         jump_prev_q <= f_jump;
         press_q <= btn ? ((press_q < LONG_PRESS_CYC) ? press_q + 32'h1 : press_q) : 32'h0;
         outage_q <= pwr ? (restored ? outage_q : 32'h0) : outage_q + 32'h1;
         // Non-volatile fault is loaded once after release
         if (boot_q) begin
            boot_q <= 1'b0;
            last_fault_q <= STORED_FAULT;
            led_fault_q <= STORED_FAULT;
         end else if (faulted) begin
            last_fault_q <= cur_fault;
            led_fault_q <= cur_fault;
         end else if (short_press) begin
            led_fault_q <= `FAULT_NONE;
         end else if (long_held) begin
            led_fault_q <= last_fault_q;
         end
         adopt_q <= (f_jump && !jump_prev_q) ? ADOPT_CYC :
                    (adopt_q != 32'h0) ? adopt_q - 32'h1 : 32'h0;
         show_q <= clear_all ? FREQ_SHOW_CYC : (show_q != 32'h0) ? show_q - 32'h1 : 32'h0;
         pulse_q <= (pulse_q != 32'h0) ? pulse_q - 32'h1 : 32'h0;
         if (clear_all || !pwr) begin
            if (clear_all) begin
               state_q <= S_IDLE;
               pulse_q <= 32'h0;
            end
         end else begin
            case (state_q)
               S_IDLE: begin
                  timed_out_q <= timed_out_q && veh;
                  if (veh && !timed_out_q) begin
                     if (OPTION_SW[`SW_DELAY]) begin
                        state_q <= S_DELAY;
                        tmr_q <= 32'h0;
                     end else begin
                        state_q <= S_CALL;
                        pres_q <= 32'h0;
                        if (bmode == `BMODE_ENTRY) pulse_q <= PULSE_CYC;
                     end
                  end
               end
               S_DELAY: begin
                  if (!veh) begin
                     state_q <= S_IDLE;
                  end else if (tmr_q >= ENTRY_CYC - 1) begin
                     state_q <= S_CALL;
                     pres_q <= 32'h0;
                     if (bmode == `BMODE_ENTRY) pulse_q <= PULSE_CYC;
                  end else begin
                     tmr_q <= tmr_q + 32'h1;
                  end
               end
               S_CALL: begin
                  pres_q <= pres_q + 32'h1;
                  if (!veh) begin
                     if (bmode == `BMODE_EXIT) pulse_q <= PULSE_CYC;
                     tmr_q <= ext_cycles(ext_sel);
                     state_q <= (ext_sel != 2'b00) ? S_EXT : S_IDLE;
                  end else if (OPTION_SW[`SW_LIMITED] && pres_q >= LIMITED_CYC - 1) begin
                     state_q <= S_IDLE;
                     timed_out_q <= 1'b1;
                  end
               end
               S_EXT: begin
                  if (veh) begin
                     state_q <= S_CALL;
                     pres_q <= 32'h0;
                  end else if (tmr_q <= 32'h1) begin
                     state_q <= S_IDLE;
                  end else begin
                     tmr_q <= tmr_q - 32'h1;
                  end
               end
               default: state_q <= S_IDLE;
            endcase
         end
      end
   end

   // Outputs registered; call frozen during outage keeps memory
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CALL_A <= 1'b0;
         CALL_B <= 1'b0;
         SENS_BOOST <= 1'b0;
         RETUNE <= 1'b0;
         ADOPT_REFERENCE <= 1'b0;
         SHOW_FREQUENCY <= 1'b0;
         OUTPUT_LED <= 1'b0;
         FAULT_LED <= 1'b0;
         SEGMENTS <= `GLYPH_ZERO;
         FAULT_STORE_DATA <= `FAULT_NONE;
         FAULT_STORE_WRITE <= 1'b0;
      end else if (CE) begin
         CALL_A <= call_on;
         case (bmode)
            `BMODE_DUP: CALL_B <= call_on;
            `BMODE_FAULT: CALL_B <= faulted;
            default: CALL_B <= (pulse_q != 32'h0);
         endcase
         SENS_BOOST <= OPTION_SW[`SW_BOOST] && call_on;
         RETUNE <= clear_all;
         ADOPT_REFERENCE <= (adopt_q == 32'h1);
         SHOW_FREQUENCY <= (show_q != 32'h0) && show_q[21];
         FAULT_STORE_DATA <= cur_fault;
         FAULT_STORE_WRITE <= faulted && (cur_fault != last_fault_q);
         FAULT_LED <= pat_lit;
         if (faulted) begin
            OUTPUT_LED <= pat_lit;
            SEGMENTS <= `GLYPH_F;
         end else begin
            OUTPUT_LED <= call_on;
            SEGMENTS <= (state_q == S_DELAY) ? `GLYPH_D :
                        (state_q == S_EXT) ? `GLYPH_E :
                        call_on ? `GLYPH_DASH : `GLYPH_ZERO;
         end
      end
   end
endmodule
`default_nettype wire

// File: loop_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module loop_front_end (
   input wire logic car,
   input wire logic [1:0] fault,
   output wire logic present,
   output wire logic open_loop,
   output wire logic shorted,
   output wire logic jump
);
   // Levels straight from the loop, no settling
   assign present = car;
   assign open_loop = fault == 2'h1;
   assign shorted = fault == 2'h2;
   assign jump = fault == 2'h3;
endmodule
`default_nettype wire

// File: detector_checker.sv
`timescale 1ns/1ps
`default_nettype none
module detector_checker #(
   parameter ENTRY_CYC = 40,
   parameter EXT_SHORT_CYC = 20,
   parameter EXT_MID_CYC = 30,
   parameter EXT_LONG_CYC = 50,
   parameter ADOPT_CYC = 30
) (
   input wire CLK,
   input wire RESET_N,
   input wire [7:0] OPTION_SW,
   input wire VEHICLE_PRESENT,
   input wire OPEN_LOOP,
   input wire SHORTED_LOOP,
   input wire INDUCTANCE_JUMP,
   input wire POWER_GOOD,
   input wire CALL_A,
   input wire CALL_B,
   input wire SENS_BOOST,
   input wire RETUNE,
   input wire ADOPT_REFERENCE,
   input wire [1:0] FAULT_STORE_DATA,
   input wire FAULT_STORE_WRITE
);
   integer pres;
   integer gone;
   integer jmp;
   wire [31:0] ext = OPTION_SW[4:3] == 2'h0 ? 0 : OPTION_SW[4:3] == 2'h1 ? EXT_SHORT_CYC :
      OPTION_SW[4:3] == 2'h2 ? EXT_MID_CYC : EXT_LONG_CYC;
   // Raw input ages; design adds sync latency on top
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pres <= 0;
         gone <= 0;
         jmp <= 0;
      end else begin
         pres <= VEHICLE_PRESENT ? pres + 1 : 0;
         gone <= VEHICLE_PRESENT ? 0 : gone + 1;
         jmp <= INDUCTANCE_JUMP ? jmp + 1 : 0;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   a_boost_needs_switch: assert property (SENS_BOOST |-> OPTION_SW[0])
      else $error("boost without switch");
   a_call_has_car: assert property ($rose(CALL_A) |-> pres >= 2)
      else $error("call without vehicle");
   a_entry_delay_min: assert property ($rose(CALL_A) && OPTION_SW[2] |-> pres >= ENTRY_CYC)
      else $error("call before entry delay");
   a_ext_time: assert property ($fell(CALL_A) && !OPTION_SW[1] && !VEHICLE_PRESENT && POWER_GOOD
      |-> gone >= ext && gone <= ext + 8)
      else $error("extension length wrong");
   a_dup_mirror: assert property (OPTION_SW[6:5] == 2'h1 && $stable(OPTION_SW)
      |-> CALL_B == CALL_A)
      else $error("output b not mirroring");
   a_fault_b_on: assert property ((OPTION_SW[6:5] == 2'h3
      && (OPEN_LOOP || SHORTED_LOOP || INDUCTANCE_JUMP))[*6] |-> CALL_B)
      else $error("output b off in fault");
   a_pulse_len: assert property ($rose(CALL_B) && !OPTION_SW[5]
      |-> CALL_B[*8] ##[2:4] !CALL_B)
      else $error("pulse length wrong");
   a_retune_once: assert property (RETUNE |=> !RETUNE)
      else $error("retune too long");
   a_adopt_time: assert property (ADOPT_REFERENCE |-> jmp >= ADOPT_CYC && jmp <= ADOPT_CYC + 6)
      else $error("adopt at wrong time");
   a_store_code: assert property (FAULT_STORE_WRITE |-> FAULT_STORE_DATA != 2'h0)
      else $error("empty code stored");
endmodule
bind loop_detector_output_control detector_checker #(.ENTRY_CYC(ENTRY_CYC),
   .EXT_SHORT_CYC(EXT_SHORT_CYC), .EXT_MID_CYC(EXT_MID_CYC), .EXT_LONG_CYC(EXT_LONG_CYC),
   .ADOPT_CYC(ADOPT_CYC)) u_chk (.CLK(CLK), .RESET_N(RESET_N), .OPTION_SW(OPTION_SW),
   .VEHICLE_PRESENT(VEHICLE_PRESENT), .OPEN_LOOP(OPEN_LOOP), .SHORTED_LOOP(SHORTED_LOOP),
   .INDUCTANCE_JUMP(INDUCTANCE_JUMP), .POWER_GOOD(POWER_GOOD), .CALL_A(CALL_A),
   .CALL_B(CALL_B), .SENS_BOOST(SENS_BOOST), .RETUNE(RETUNE), .ADOPT_REFERENCE(ADOPT_REFERENCE),
   .FAULT_STORE_DATA(FAULT_STORE_DATA), .FAULT_STORE_WRITE(FAULT_STORE_WRITE));
`default_nettype wire

// File: loop_detector_output_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module loop_detector_output_control_tb;
   logic clk = 0, rst_n = 0, car = 0, btn = 0, pg = 1, ce = 1;
   logic [1:0] stored = 2'h2;
   // Shortened timings so every scenario fits in a short run
   localparam integer entry_cyc = 40, pulse_cyc = 10, ext_s = 20, ext_m = 30, ext_l = 50;
   localparam integer limit_cyc = 1000, memory_cyc = 40, adopt_cyc = 30, press_cyc = 30;
   localparam integer show_cyc = 50, slot_cyc = 10;
   logic [7:0] sw = 8'h00;
   logic [1:0] fault = 2'h0;
   logic [1:0] last_d = 2'h0;
   wire present, open_l, short_l, jump_l, call_a, call_b, boost, retune, adopt, store_w;
   wire [1:0] store_d;
   wire [4:0] mon = {adopt, retune, store_w, call_b, call_a};
   integer n_errors = 0, comparisons = 0, b_hi = 0, f_hi = 0, t, b0, f0, k;
   integer ext_c [0:3] = '{0, 20, 30, 50};
   wire fault_led;
   initial begin
      forever #50 clk = ~clk;
   end
   // Free counters so pulse widths are measured even while a task idles
   always @(posedge clk) begin
      b_hi <= b_hi + call_b;
      f_hi <= f_hi + fault_led;
      if (store_w) last_d <= store_d;
   end
   loop_front_end u_fe (.car(car), .fault(fault), .present(present), .open_loop(open_l),
      .shorted(short_l), .jump(jump_l));
   loop_detector_output_control #(.ENTRY_CYC(entry_cyc), .PULSE_CYC(pulse_cyc),
      .EXT_SHORT_CYC(ext_s), .EXT_MID_CYC(ext_m), .EXT_LONG_CYC(ext_l), .LIMITED_CYC(limit_cyc),
      .MEMORY_CYC(memory_cyc), .ADOPT_CYC(adopt_cyc), .LONG_PRESS_CYC(press_cyc),
      .FREQ_SHOW_CYC(show_cyc), .SLOT_CYC(slot_cyc)) u_dut (.CLK(clk), .RESET_N(rst_n),
      .CE(ce), .OPTION_SW(sw), .VEHICLE_PRESENT(present), .OPEN_LOOP(open_l),
      .SHORTED_LOOP(short_l), .INDUCTANCE_JUMP(jump_l), .RESET_BUTTON(btn), .POWER_GOOD(pg),
      .STORED_FAULT(stored), .CALL_A(call_a), .CALL_B(call_b), .SENS_BOOST(boost),
      .RETUNE(retune), .ADOPT_REFERENCE(adopt), .SHOW_FREQUENCY(), .OUTPUT_LED(),
      .FAULT_LED(fault_led), .SEGMENTS(), .FAULT_STORE_DATA(store_d), .FAULT_STORE_WRITE(store_w));
   task give_verdict;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task check(input [8*8:1] name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("unexpected %0s: expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task wait_for(input integer i, input logic v, input integer n);
      t = 0;
      while (mon[i] !== v) begin
         @(posedge clk);
         t = t + 1;
         if (t > n) begin
            n_errors = n_errors + 1;
            give_verdict;
         end
      end
   endtask
   task t_presence;
      sw <= 8'h01;
      b0 = b_hi;
      ce <= 1'b0;
      car <= 1'b1;
      tick(20);
      check("freeze", call_a, 1'b0);
      ce <= 1'b1;
      wait_for(0, 1'b1, 10);
      tick(300);
      check("boost", boost, 1'b1);
      check("hold", call_a, 1'b1);
      check("entryp", b_hi - b0, 10);
      car <= 1'b0;
      wait_for(0, 1'b0, 10);
      tick(3);
      check("unboost", boost, 1'b0);
   endtask
   task t_ext;
      for (k = 1; k < 4; k = k + 1) begin
         sw <= {3'h2, k[1:0], 3'h0};
         car <= 1'b1;
         wait_for(0, 1'b1, 10);
         tick(20);
         check("nopulse", call_b, 1'b0);
         b0 = b_hi;
         car <= 1'b0;
         wait_for(0, 1'b0, 80);
         check("ext", t >= ext_c[k] && t <= ext_c[k] + 8, 1'b1);
         check("exitp", b_hi - b0, 10);
      end
   endtask
   task t_reentry;
      sw <= 8'h18;
      car <= 1'b1;
      wait_for(0, 1'b1, 10);
      car <= 1'b0;
      tick(10);
      car <= 1'b1;
      tick(70);
      check("reenter", call_a, 1'b1);
      car <= 1'b0;
      wait_for(0, 1'b0, 80);
      check("restart", t >= 50, 1'b1);
   endtask
   task t_delay;
      sw <= 8'h24;
      b0 = b_hi;
      car <= 1'b1;
      tick(20);
      car <= 1'b0;
      tick(10);
      check("short", call_a | (b_hi != b0), 1'b0);
      car <= 1'b1;
      wait_for(0, 1'b1, 60);
      check("delay", t >= 40, 1'b1);
      tick(2);
      check("dup", call_b, 1'b1);
      car <= 1'b0;
      wait_for(0, 1'b0, 20);
   endtask
   task t_limited;
      sw <= 8'h02;
      car <= 1'b1;
      wait_for(0, 1'b1, 10);
      wait_for(0, 1'b0, 1100);
      check("limit", t >= 990, 1'b1);
      car <= 1'b0;
      sw <= 8'h00;
      tick(5);
      car <= 1'b1;
      wait_for(0, 1'b1, 10);
      pg <= 1'b0;
      tick(20);
      pg <= 1'b1;
      tick(10);
      check("memory", call_a, 1'b1);
      car <= 1'b0;
      wait_for(0, 1'b0, 20);
   endtask
   task t_fault;
      sw <= 8'h60;
      fault <= 2'h1;
      wait_for(1, 1'b1, 10);
      tick(1);
      check("stored", last_d, 2'h1);
      fault <= 2'h0;
      wait_for(1, 1'b0, 10);
      f0 = f_hi;
      tick(200);
      check("healed", f_hi - f0 >= 10 && f_hi - f0 <= 30, 1'b1);
      fault <= 2'h3;
      wait_for(4, 1'b1, 40);
      check("adopt", t >= 30, 1'b1);
      fault <= 2'h0;
      btn <= 1'b1;
      tick(5);
      btn <= 1'b0;
      wait_for(3, 1'b1, 10);
      tick(10);
      f0 = f_hi;
      tick(200);
      check("cleared", f_hi - f0, 0);
      btn <= 1'b1;
      tick(40);
      f0 = f_hi;
      tick(200);
      check("review", f_hi > f0, 1'b1);
      btn <= 1'b0;
   endtask
   initial begin
      tick(8);
      rst_n <= 1'b1;
      f0 = f_hi;
      tick(200);
      check("powerup", f_hi - f0 >= 20 && f_hi - f0 <= 60, 1'b1);
      t_presence;
      t_ext;
      t_reentry;
      t_delay;
      t_limited;
      t_fault;
      give_verdict;
   end
endmodule
`default_nettype wire
